// ===== hdl/dtfc_params.svh
// offsets, field positions, reset values and codes of the training fifo and calibration block
`ifndef DTFC_PARAMS_SVH
`define DTFC_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define DTFC_OFF_PAT0 8'h00
`define DTFC_OFF_PAT1 8'h04
`define DTFC_OFF_INV_LO 8'h08
`define DTFC_OFF_INV_HI 8'h0c
`define DTFC_OFF_IOCFG 8'h10
`define DTFC_OFF_SPCTL 8'h14
`define DTFC_OFF_LAT 8'h18
`define DTFC_OFF_STAT 8'h1c
// ----------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------
`define DTFC_RST_PAT0 8'h5a
`define DTFC_RST_PAT1 8'h3c
`define DTFC_RST_INV 8'h55
`define DTFC_RST_IOCFG 8'h00
`define DTFC_RST_SPCTL 8'h00
`define DTFC_RST_RL 5'h06
`define DTFC_RST_WL 5'h04
`define DTFC_IOCFG_WDBI_BIT 7
`define DTFC_IOCFG_RDBI_BIT 6
`define DTFC_SPCTL_DM_DIS_BIT 5
`define DTFC_LAT_WL_LSB 8
// ----------------------------------------------------------------
// command codes on the command pins, multi-purpose operands
// ----------------------------------------------------------------
`define DTFC_CMD_DES 4'h0
`define DTFC_CMD_MPC 4'h1
`define DTFC_CMD_CAS2 4'h2
`define DTFC_CMD_WR 4'h3
`define DTFC_CMD_MWR 4'h4
`define DTFC_CMD_RD 4'h5
`define DTFC_CMD_MRR 4'h6
`define DTFC_CMD_PDE 4'h7
`define DTFC_CMD_SRPDE 4'h8
`define DTFC_MPC_EN_BIT 6
`define DTFC_MPC_RDFIFO 6'h01
`define DTFC_MPC_RDCAL 6'h03
`define DTFC_MPC_WRFIFO 6'h07
// ----------------------------------------------------------------
// sizes and bus answers
// ----------------------------------------------------------------
`define DTFC_BL 16
`define DTFC_DEPTH 5
`define DTFC_LAT_SR_W 32
`define DTFC_RESP_OKAY 2'h0
`define DTFC_RESP_DECERR 2'h3
`endif

// ===== hdl/dtfc_pkg.sv
// types shared by the training fifo and calibration block
package dtfc_pkg;
  typedef logic [15:0] dtfc_word_t;
  typedef enum logic [2:0] {DTFC_RK_IDLE = 3'b001, DTFC_RK_CAL = 3'b010,
    DTFC_RK_FIFO = 3'b100} dtfc_rkind_e;
  typedef enum logic [3:0] {DTFC_MP_NONE = 4'b0001, DTFC_MP_CAL = 4'b0010,
    DTFC_MP_RDF = 4'b0100, DTFC_MP_WRF = 4'b1000} dtfc_mpc_e;
  typedef enum logic [1:0] {DTFC_BW_COLLECT = 2'b01, DTFC_BW_RESP = 2'b10} dtfc_bw_e;
endpackage : dtfc_pkg

// ===== hdl/dtfc_top.sv
// dram training fifo and read calibration pattern source with axi4-lite registers
// Behaviour
// [R1] calibration drives first then second pattern byte on all dq and both dmi lanes
// [R2] each pattern byte goes out lowest bit first
// [R3] dq lanes invert where mask bit set; dmi lanes never invert
// [R4] low mask covers lanes 0-7, high mask lanes 8-15, bit n to lane n
// [R5] dmi lanes float only when dm, write dbi and read dbi all disabled
// [R6] no bus inversion applied to calibration output
// [R7] calibration burst starts after programmed read latency, like a sixteen-beat read
// [R8] controller waits extra delay after power-down exit before calibration
// [R9] multi-purpose command with operand bit six low is a no-operation
// [R10] controller follows fifo or calibration command at once with zeroed second column command
// [R11] fifo write data follows write latency counted from second column command
// [R12] fifo read data follows read latency counted from second column command
// [R13] fifo holds five entries of sixteen beats per lane
// [R14] fifo reads are non-destructive; entries stay until overwritten
// [R15] never-written entries read back as defined logic levels
// [R16] controller limits mode register writes between fifo write and fifo read
// [R17] fifo reads return entries zero to four then wrap to zero
// [R18] write pointer resets at reset, power-down entry and self-refresh power-down entry
// [R19] fifo write/read advance own pointer; array read advances both
// [R20] controller issues no array reads during write training
// [R21] controller ends training with read count equal write count plus multiple of five
// [R22] fifo writes accepted whatever the bank or refresh state
// [R23] fifo writes may follow back to back every sixteen beats
// [R24] sixth consecutive fifo write overwrites the first entry
// [R25] pointers count modulo five; read path selects entry at read pointer
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dtfc_params.svh"
module dtfc_top
  import dtfc_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // axi4-lite register slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // link pins from the controller
  input wire logic LINK_CK,
  input wire logic RESET_N,
  input wire logic [3:0] CMD,
  input wire logic [6:0] OP,
  input wire logic [15:0] DQ_IN,
  // data pins toward the controller
  output logic [15:0] DQ_OUT,
  output logic DQ_OE,
  output logic [1:0] DMI_OUT,
  output logic DMI_OE
);
  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = (p == 3'(`DTFC_DEPTH - 1)) ? 3'h0 : p + 3'h1; // R25
  endfunction : ptr_inc
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction : lane0

  // ----------------------------------------------------------------
  // pin synchronisers and link edge detect
  // ----------------------------------------------------------------
  logic [2:0] ck_sy_r;
  logic [1:0] rstn_sy_r;
  logic [3:0] cmd_m_r, cmd_s_r;
  logic [6:0] op_m_r, op_s_r;
  dtfc_word_t dq_m_r, dq_s_r;
  logic tick;
  always_ff @(posedge CLOCK) begin
    ck_sy_r <= {ck_sy_r[1:0], LINK_CK};
    rstn_sy_r <= {rstn_sy_r[0], RESET_N};
    cmd_m_r <= CMD;
    cmd_s_r <= cmd_m_r;
    op_m_r <= OP;
    op_s_r <= op_m_r;
    dq_m_r <= DQ_IN;
    dq_s_r <= dq_m_r;
  end
  // sample at the link falling edge: the controller changes pins on the rising edge
  assign tick = ck_sy_r[2] & ~ck_sy_r[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pat0_r, pat1_r, inv_lo_r, inv_hi_r, iocfg_r, spctl_r;
  logic [4:0] rl_r, wl_r;
  logic [2:0] wr_ptr_r, rd_ptr_r;
  dtfc_rkind_e rkind_r;
  dtfc_bw_e bw_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;
  assign do_wr = (bw_r == DTFC_BW_COLLECT) && aw_got_r && w_got_r;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      bw_r <= DTFC_BW_COLLECT;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `DTFC_RESP_OKAY;
    end else begin
      // address and data are taken in either order, each held until both arrived
      S_AXI_AWREADY <= (bw_r == DTFC_BW_COLLECT) && !aw_got_r && !S_AXI_AWREADY;
      S_AXI_WREADY <= (bw_r == DTFC_BW_COLLECT) && !w_got_r && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      unique case (bw_r)
        DTFC_BW_COLLECT: if (do_wr) begin
          bw_r <= DTFC_BW_RESP;
          S_AXI_BVALID <= 1'b1;
          S_AXI_BRESP <= (awaddr_r[7:2] <= `DTFC_OFF_STAT >> 2) && awaddr_r != `DTFC_OFF_STAT ?
                         `DTFC_RESP_OKAY : `DTFC_RESP_DECERR;
        end
        DTFC_BW_RESP: if (S_AXI_BREADY) begin
          bw_r <= DTFC_BW_COLLECT;
          S_AXI_BVALID <= 1'b0;
          aw_got_r <= 1'b0;
          w_got_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pat0_r <= `DTFC_RST_PAT0;
      pat1_r <= `DTFC_RST_PAT1;
      inv_lo_r <= `DTFC_RST_INV;
      inv_hi_r <= `DTFC_RST_INV;
      iocfg_r <= `DTFC_RST_IOCFG;
      spctl_r <= `DTFC_RST_SPCTL;
      rl_r <= `DTFC_RST_RL;
      wl_r <= `DTFC_RST_WL;
    end else if (do_wr) begin
      unique case ({awaddr_r[7:2], 2'b00})
        `DTFC_OFF_PAT0: pat0_r <= lane0(pat0_r, wdata_r, wstrb_r);
        `DTFC_OFF_PAT1: pat1_r <= lane0(pat1_r, wdata_r, wstrb_r);
        `DTFC_OFF_INV_LO: inv_lo_r <= lane0(inv_lo_r, wdata_r, wstrb_r);
        `DTFC_OFF_INV_HI: inv_hi_r <= lane0(inv_hi_r, wdata_r, wstrb_r);
        `DTFC_OFF_IOCFG: iocfg_r <= lane0(iocfg_r, wdata_r, wstrb_r);
        `DTFC_OFF_SPCTL: spctl_r <= lane0(spctl_r, wdata_r, wstrb_r);
        `DTFC_OFF_LAT: begin
          if (wstrb_r[0]) rl_r <= wdata_r[4:0];
          if (wstrb_r[1]) wl_r <= wdata_r[`DTFC_LAT_WL_LSB +: 5];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `DTFC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= `DTFC_RESP_OKAY;
        unique case ({S_AXI_ARADDR[7:2], 2'b00})
          `DTFC_OFF_PAT0: S_AXI_RDATA <= {24'h0, pat0_r};
          `DTFC_OFF_PAT1: S_AXI_RDATA <= {24'h0, pat1_r};
          `DTFC_OFF_INV_LO: S_AXI_RDATA <= {24'h0, inv_lo_r};
          `DTFC_OFF_INV_HI: S_AXI_RDATA <= {24'h0, inv_hi_r};
          `DTFC_OFF_IOCFG: S_AXI_RDATA <= {24'h0, iocfg_r};
          `DTFC_OFF_SPCTL: S_AXI_RDATA <= {24'h0, spctl_r};
          `DTFC_OFF_LAT: S_AXI_RDATA <= {19'h0, wl_r, 3'h0, rl_r};
          `DTFC_OFF_STAT: S_AXI_RDATA <= {25'h0, rkind_r != DTFC_RK_IDLE, rd_ptr_r,
                                          wr_ptr_r[2:0]};
          default: begin
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `DTFC_RESP_DECERR;
          end
        endcase
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // command decode and latency delay lines
  // ----------------------------------------------------------------
  dtfc_mpc_e mpc_r;
  logic [`DTFC_LAT_SR_W-1:0] cal_sr_r, rdf_sr_r, wrf_sr_r;
  logic cas_ok, go_cal, go_rdf, go_wrf, fire_cal, fire_rdf, fire_wrf, ptr_clr, arr_rd;
  logic [4:0] rl_ix, wl_ix;
  // the zeroed second column command is what arms the transfer
  assign cas_ok = tick && cmd_s_r == `DTFC_CMD_CAS2 && op_s_r == 7'h00; // R10
  assign go_cal = cas_ok && mpc_r == DTFC_MP_CAL;
  assign go_rdf = cas_ok && mpc_r == DTFC_MP_RDF;
  assign go_wrf = cas_ok && mpc_r == DTFC_MP_WRF; // R22
  assign rl_ix = (rl_r == 5'h00) ? 5'h00 : rl_r - 5'h01;
  assign wl_ix = (wl_r == 5'h00) ? 5'h00 : wl_r - 5'h01;
  assign fire_cal = tick && cal_sr_r[rl_ix]; // R7
  assign fire_rdf = tick && rdf_sr_r[rl_ix]; // R12
  assign fire_wrf = tick && wrf_sr_r[wl_ix]; // R11
  assign ptr_clr = !rstn_sy_r[1] ||
                   (tick && (cmd_s_r == `DTFC_CMD_PDE || cmd_s_r == `DTFC_CMD_SRPDE));
  assign arr_rd = tick && cmd_s_r == `DTFC_CMD_RD;

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      mpc_r <= DTFC_MP_NONE;
      cal_sr_r <= '0;
      rdf_sr_r <= '0;
      wrf_sr_r <= '0;
    end else if (tick) begin
      cal_sr_r <= {cal_sr_r[`DTFC_LAT_SR_W-2:0], go_cal};
      rdf_sr_r <= {rdf_sr_r[`DTFC_LAT_SR_W-2:0], go_rdf};
      wrf_sr_r <= {wrf_sr_r[`DTFC_LAT_SR_W-2:0], go_wrf};
      mpc_r <= DTFC_MP_NONE;
      if (cmd_s_r == `DTFC_CMD_MPC && op_s_r[`DTFC_MPC_EN_BIT]) begin // R9
        unique case (op_s_r[5:0])
          `DTFC_MPC_RDCAL: mpc_r <= DTFC_MP_CAL;
          `DTFC_MPC_RDFIFO: mpc_r <= DTFC_MP_RDF;
          `DTFC_MPC_WRFIFO: mpc_r <= DTFC_MP_WRF;
          default: mpc_r <= DTFC_MP_NONE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // training fifo storage and pointers
  // ----------------------------------------------------------------
  // flops cleared at reset so unwritten entries read as defined levels
  dtfc_word_t mem_r [`DTFC_DEPTH][`DTFC_BL]; // R13 R15
  logic [2:0] widx_r;
  logic [3:0] wbeat_r;
  logic wact_r;
  always_ff @(posedge CLOCK) begin
    if (SRST || ptr_clr) begin
      wr_ptr_r <= 3'h0; // R18
      rd_ptr_r <= 3'h0;
    end else begin
      if (fire_wrf || arr_rd) wr_ptr_r <= ptr_inc(wr_ptr_r); // R19 R24
      if (fire_rdf || arr_rd) rd_ptr_r <= ptr_inc(rd_ptr_r); // R17 R19
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wact_r <= 1'b0;
      widx_r <= 3'h0;
      wbeat_r <= 4'h0;
    end else if (fire_wrf) begin
      wact_r <= 1'b1;
      widx_r <= wr_ptr_r;
      wbeat_r <= 4'h1;
    end else if (tick && wact_r) begin
      wbeat_r <= wbeat_r + 4'h1;
      wact_r <= wbeat_r != 4'(`DTFC_BL - 1);
    end
  end
  // reads never touch storage, so fifo contents survive any number of reads
  for (genvar e = 0; e < `DTFC_DEPTH; e++) begin : g_ent // R14
    always_ff @(posedge CLOCK) begin
      if (SRST) begin
        for (int b = 0; b < `DTFC_BL; b++) mem_r[e][b] <= 16'h0000;
      end else if (fire_wrf && wr_ptr_r == 3'(e)) begin
        mem_r[e][0] <= dq_s_r;
      end else if (tick && wact_r && widx_r == 3'(e)) begin
        mem_r[e][wbeat_r] <= dq_s_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // read burst engine: calibration pattern or fifo entry
  // ----------------------------------------------------------------
  logic [2:0] ridx_r;
  logic [3:0] rbeat_r;
  logic [15:0] pat;
  logic dmi_en, fire_rd;
  dtfc_rkind_e rk_nxt;
  logic [2:0] ri_nxt;
  logic [3:0] rb_nxt;
  dtfc_word_t dq_nxt;
  assign pat = {pat1_r, pat0_r}; // R1 R2
  assign dmi_en = !(spctl_r[`DTFC_SPCTL_DM_DIS_BIT] && !iocfg_r[`DTFC_IOCFG_WDBI_BIT] &&
                    !iocfg_r[`DTFC_IOCFG_RDBI_BIT]); // R5
  assign fire_rd = fire_cal || fire_rdf;
  always_comb begin
    rk_nxt = rkind_r;
    ri_nxt = ridx_r;
    rb_nxt = rbeat_r + 4'h1;
    if (fire_cal) rk_nxt = DTFC_RK_CAL;
    else if (fire_rdf) rk_nxt = DTFC_RK_FIFO;
    else if (rbeat_r == 4'(`DTFC_BL - 1)) rk_nxt = DTFC_RK_IDLE;
    if (fire_rdf) ri_nxt = rd_ptr_r; // R25
    if (fire_rd) rb_nxt = 4'h0;
    // pattern bits never pass a bus inversion stage
    if (rk_nxt == DTFC_RK_CAL) dq_nxt = {16{pat[rb_nxt]}} ^ {inv_hi_r, inv_lo_r}; // R3 R4 R6
    else dq_nxt = mem_r[ri_nxt][rb_nxt];
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rkind_r <= DTFC_RK_IDLE;
      ridx_r <= 3'h0;
      rbeat_r <= 4'h0;
      DQ_OUT <= 16'h0000;
      DQ_OE <= 1'b0;
      DMI_OUT <= 2'h0;
      DMI_OE <= 1'b0;
    end else if (tick && (fire_rd || rkind_r != DTFC_RK_IDLE)) begin
      rkind_r <= rk_nxt;
      ridx_r <= ri_nxt;
      rbeat_r <= rb_nxt;
      DQ_OUT <= (rk_nxt == DTFC_RK_IDLE) ? 16'h0000 : dq_nxt;
      DQ_OE <= rk_nxt != DTFC_RK_IDLE;
      DMI_OUT <= (rk_nxt == DTFC_RK_CAL) ? {2{pat[rb_nxt]}} : 2'h0; // R3
      DMI_OE <= rk_nxt == DTFC_RK_CAL && dmi_en; // R5
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_DMI_HIZ: assert property (@(posedge CLOCK) disable iff (SRST) // R5
    DMI_OE |-> $past(dmi_en)) else $error("dmi driven while all dmi functions off");
  AST_DMI_NOINV: assert property (@(posedge CLOCK) disable iff (SRST) // R3
    DMI_OE |-> DMI_OUT[0] == DMI_OUT[1]) else $error("dmi lanes differ");
  AST_INV_MAP: assert property (@(posedge CLOCK) disable iff (SRST) // R4
    (rkind_r == DTFC_RK_CAL && $stable(inv_lo_r) && $stable(inv_hi_r))
    |-> DQ_OUT == ({16{pat[rbeat_r]}} ^ {inv_hi_r, inv_lo_r}))
    else $error("calibration lane inversion wrong");
  AST_LSB_FIRST: assert property (@(posedge CLOCK) disable iff (SRST) // R2
    fire_cal |=> DQ_OE && rbeat_r == 4'h0 && DMI_OUT[0] == $past(pat0_r[0]))
    else $error("first calibration beat is not bit zero");
  AST_BURST_END: assert property (@(posedge CLOCK) disable iff (SRST) // R1
    (tick && DQ_OE && rbeat_r == 4'hf && !fire_rd) |=> !DQ_OE)
    else $error("read burst not sixteen beats");
  AST_RD_WRAP: assert property (@(posedge CLOCK) disable iff (SRST) // R17
    (fire_rdf && !arr_rd && !ptr_clr && rd_ptr_r == 3'h4) |=> rd_ptr_r == 3'h0)
    else $error("read pointer did not wrap after entry four");
  AST_PTR_RANGE: assert property (@(posedge CLOCK) disable iff (SRST) // R25
    wr_ptr_r < 3'h5 && rd_ptr_r < 3'h5) else $error("pointer outside five entries");
  AST_PD_CLR: assert property (@(posedge CLOCK) disable iff (SRST) // R18
    (tick && cmd_s_r == `DTFC_CMD_PDE) |=> wr_ptr_r == 3'h0)
    else $error("write pointer kept at power-down entry");
  AST_ARRAY_RD: assert property (@(posedge CLOCK) disable iff (SRST) // R19
    (arr_rd && !ptr_clr) |=> wr_ptr_r == ptr_inc($past(wr_ptr_r)) &&
    rd_ptr_r == ptr_inc($past(rd_ptr_r))) else $error("array read left a pointer");
  AST_MPC_NOP: assert property (@(posedge CLOCK) disable iff (SRST) // R9
    (tick && cmd_s_r == `DTFC_CMD_MPC && !op_s_r[`DTFC_MPC_EN_BIT]) |=> mpc_r == DTFC_MP_NONE)
    else $error("multi-purpose command with bit six low armed a transfer");
endmodule : dtfc_top
`default_nettype wire

// ===== bench/dtfc_ctrl_model.sv
// memory controller model: free link clock, commands, write beats, read capture
`timescale 1ns/1ps
`default_nettype none
`include "dtfc_params.svh"
module dtfc_ctrl_model
  import dtfc_pkg::*;
(
  // link pins toward the device
  output logic LINK_CK,
  output logic RESET_N,
  output logic [3:0] CMD,
  output logic [6:0] OP,
  output logic [15:0] DQ_IN,
  // data pins from the device
  input wire logic [15:0] DQ_OUT,
  input wire logic DQ_OE,
  input wire logic [1:0] DMI_OUT,
  input wire logic DMI_OE
);
  // a command clock runs free; the 7 ns skew keeps its edges clear of CLOCK edges
  initial begin
    LINK_CK = 1'b0;
    #7;
    forever #160 LINK_CK = ~LINK_CK;
  end
  initial begin
    {RESET_N, CMD, OP, DQ_IN} = '0;
    repeat (2) @(negedge LINK_CK);
    RESET_N <= 1'b1;
  end
  // launched at the rising edge, taken by the device at the falling one
  task automatic tick(input logic [3:0] c, input logic [6:0] o, input dtfc_word_t d);
    @(posedge LINK_CK);
    CMD <= c;
    OP <= o;
    DQ_IN <= d;
    @(negedge LINK_CK);
  endtask : tick
  task automatic pin_reset();
    @(posedge LINK_CK);
    RESET_N <= 1'b0;
    repeat (2) @(negedge LINK_CK);
    RESET_N <= 1'b1;
  endtask : pin_reset
  // oe slot 0 is the cycle before beat 0, slot 17 the one after beat 15
  task automatic burst(input logic [5:0] fn, input int rl, input int wl,
    input dtfc_word_t wd [16], output dtfc_word_t rd [16], output logic [1:0] dm [16],
    output logic [17:0] oe, output logic [17:0] dmoe);
    int j;
    dtfc_word_t w;
    tick(`DTFC_CMD_MPC, {1'b1, fn}, ~DQ_IN);
    tick(`DTFC_CMD_CAS2, 7'h00, ~DQ_IN);
    for (int k = 1; k <= rl + 17; k++) begin
      j = k - wl;
      // an undriven bus shows the inverse of its last value, never a stale copy
      w = (fn == `DTFC_MPC_WRFIFO && j >= 0 && j < 16) ? wd[j] : ~DQ_IN;
      tick(`DTFC_CMD_DES, 7'h00, w);
      j = k - rl;
      if (j >= 0 && j < 18) begin
        oe[j] = DQ_OE;
        dmoe[j] = DMI_OE;
      end
      if (j > 0 && j < 17) begin
        rd[j - 1] = DQ_OUT;
        dm[j - 1] = DMI_OUT;
      end
    end
  endtask : burst
endmodule : dtfc_ctrl_model
`default_nettype wire

// ===== bench/dtfc_top_tb.sv
// bench: axi4-lite registers, calibration bursts, training fifo and its pointers
`timescale 1ns/1ps
`default_nettype none
`include "dtfc_params.svh"
module dtfc_top_tb
  import dtfc_pkg::*;
  ;
  logic CLOCK, SRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, LINK_CK, RESET_N, DQ_OE, DMI_OE;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB, CMD;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, DMI_OUT;
  logic [6:0] OP;
  dtfc_word_t DQ_IN, DQ_OUT;
  int failures = 0;
  int samples_checked = 0;
  dtfc_top dtfc_top_i (.*);
  dtfc_ctrl_model dtfc_ctrl_model_i (.*);
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    S_AXI_BREADY <= 1'b0;
    r = S_AXI_BRESP;
    if (t == 100) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, t, 99);
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge CLOCK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    S_AXI_RREADY <= 1'b0;
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    if (t == 100) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, t, 99);
    end
  endtask : axi_rd
  task automatic lk(input logic [3:0] c);
    dtfc_ctrl_model_i.tick(c, 7'h00, ~DQ_IN);
  endtask : lk
  function automatic dtfc_word_t pat_of(input int e, input int n);
    return {e[7:0], 4'(n), 4'(15 - n)};
  endfunction : pat_of
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] rv [8] = '{32'h5a, 32'h3c, 32'h55, 32'h55, 32'h0, 32'h0, 32'h0406, 32'h0};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      axi_rd(8'(i * 4), d, r);
      chk(d, rv[i]);
      chk(r, `DTFC_RESP_OKAY);
    end
    axi_wr(`DTFC_OFF_STAT, 32'h3f, r);
    chk(r, `DTFC_RESP_DECERR);
    axi_wr(8'h20, 32'h3f, r);
    chk(r, `DTFC_RESP_DECERR);
    axi_rd(8'h20, d, r);
    chk(r, `DTFC_RESP_DECERR);
    chk(d, 32'h0);
    axi_rd(`DTFC_OFF_STAT, d, r);
    chk(d, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_cal();
    dtfc_word_t wd [16], rd [16];
    logic [1:0] dm [16];
    logic [17:0] oe, dmoe;
    logic [15:0] pat;
    logic [1:0] r;
    logic en;
    pat = 16'h591c;
    axi_wr(`DTFC_OFF_PAT0, 32'h1c, r);
    axi_wr(`DTFC_OFF_PAT1, 32'h59, r);
    // distinct masks per byte expose a lane mapped to the wrong mask
    axi_wr(`DTFC_OFF_INV_HI, 32'h0f, r);
    for (int m = 0; m < 8; m++) begin
      axi_wr(`DTFC_OFF_SPCTL, 32'(m[2]) << `DTFC_SPCTL_DM_DIS_BIT, r);
      axi_wr(`DTFC_OFF_IOCFG, 32'(m[1:0]) << `DTFC_IOCFG_RDBI_BIT, r);
      en = (m != 4);
      dtfc_ctrl_model_i.burst(`DTFC_MPC_RDCAL, 6, 4, wd, rd, dm, oe, dmoe);
      chk(oe, 18'h1fffe);
      chk(dmoe, en ? 18'h1fffe : 18'h0);
      for (int n = 0; n < 16; n++) begin
        chk(rd[n], {8'h0f ^ {8{pat[n]}}, 8'h55 ^ {8{pat[n]}}});
        if (en) chk(dm[n], {2{pat[n]}});
      end
    end
    $display("t_cal done");
  endtask : t_cal
  task automatic t_fifo();
    dtfc_word_t wd [16], rd [16];
    logic [1:0] dm [16];
    logic [17:0] oe, dmoe;
    logic [31:0] d;
    logic [1:0] r;
    int e;
    axi_wr(`DTFC_OFF_LAT, 32'h0203, r);
    dtfc_ctrl_model_i.burst(`DTFC_MPC_RDFIFO, 3, 2, wd, rd, dm, oe, dmoe);
    for (int n = 0; n < 16; n++) chk($isunknown(rd[n]), 1'b0);
    dtfc_ctrl_model_i.pin_reset();
    axi_rd(`DTFC_OFF_STAT, d, r);
    chk(d, 32'h0);
    for (int k = 0; k < 6; k++) begin
      for (int n = 0; n < 16; n++) wd[n] = pat_of(k, n);
      dtfc_ctrl_model_i.burst(`DTFC_MPC_WRFIFO, 3, 2, wd, rd, dm, oe, dmoe);
    end
    axi_rd(`DTFC_OFF_STAT, d, r);
    chk(d, 32'h1);
    // no register writes until the reads are done
    for (int k = 0; k < 6; k++) begin
      e = (k % 5 == 0) ? 5 : k % 5;
      dtfc_ctrl_model_i.burst(`DTFC_MPC_RDFIFO, 3, 2, wd, rd, dm, oe, dmoe);
      chk(oe, 18'h1fffe);
      for (int n = 0; n < 16; n++) chk(rd[n], pat_of(e, n));
    end
    axi_rd(`DTFC_OFF_STAT, d, r);
    chk(d, 32'h09);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_ptr();
    logic [31:0] d;
    logic [1:0] r;
    dtfc_ctrl_model_i.tick(`DTFC_CMD_MPC, {1'b0, `DTFC_MPC_RDCAL}, ~DQ_IN);
    lk(`DTFC_CMD_CAS2);
    for (int k = 0; k < 12; k++) begin
      lk(`DTFC_CMD_DES);
      chk(DQ_OE, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      lk(`DTFC_CMD_RD);
      lk(`DTFC_CMD_DES);
      axi_rd(`DTFC_OFF_STAT, d, r);
      chk(d, i ? 32'h09 : 32'h12);
      lk(i ? `DTFC_CMD_SRPDE : `DTFC_CMD_PDE);
      repeat (4) lk(`DTFC_CMD_DES);
      axi_rd(`DTFC_OFF_STAT, d, r);
      chk(d, 32'h0);
    end
    $display("t_ptr done");
  endtask : t_ptr
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  initial begin
    {SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h20;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    repeat (8) @(posedge CLOCK);
    SRST <= 1'b0;
    // the link synchronisers need a full link period before the first command
    repeat (16) @(posedge CLOCK);
    t_regs();
    t_cal();
    t_fifo();
    t_ptr();
    wrap_up();
  end
  initial begin
    #1000000;
    $display("watchdog expired");
    failures++;
    wrap_up();
  end
endmodule : dtfc_top_tb
`default_nettype wire
